// ---- rtl/lbx_exec.sv ----
// Execute stage for AND-complement, AND-immediate and branch instructions
// Functional notes
// - Opcode 31 extended 60 writes source AND NOT second into the dest.
// - With the record bit set, X-form logic updates field zero from result.
// - Opcode 28 ANDs source with the zero-extended immediate, records always.
// - Opcode 29 ANDs source with immediate in the upper half, records always.
// - Naming an unimplemented general register raises an illegal exception.
// - Opcode 18 displacement is the 24-bit target with two zeros, sign-ext.
// - Absolute bit set uses base zero, else the branch's own address.
// - Link bit set writes address plus 4 to link, taken or not.
// - Opcode 16 decrements the count before the test when option bit 2 is 0.
// - Conditional branch taken iff count test and condition test both pass; opcode 18 always taken.
// - The condition-select field picks one bit of condition field zero.
// - A conditional branch with bits 11 to 13 nonzero is illegal.
// - Prediction hints in options and bits 19 to 20 are ignored.
// - Opcode 19 extended 528 branches to count upper 30 bits with zeros.
// - Branch-to-count with option bit 2 clear is illegal, no decrement.
// - Opcode 19 extended 16 branches to link upper 30 bits, decrements like opcode 16.
`timescale 1ns/100ps
module lbx_exec (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire lbx_pkg::lbx_issue_t issue_i,
  output lbx_pkg::lbx_gpr_wr_t gpr_wr_o,
  output lbx_pkg::lbx_field0_t condition_field_zero_o,
  output logic [31:0] count_register_o,
  output logic [31:0] link_register_o,
  output logic [31:0] next_instr_address_o,
  output logic redirect_o,
  output logic done_o,
  output logic illegal_o
);
  lbx_pkg::lbx_state_t state;
  lbx_pkg::lbx_state_t next_state;
  lbx_pkg::lbx_field0_t field0;
  logic [31:0] count_register;
  logic [31:0] link_register;

  // Register number check shared by every register-naming form
  function automatic logic reg_ok(input logic [4:0] r);
    reg_ok = {1'b0, r} < lbx_pkg::NUM_GPRS;
  endfunction

  function automatic lbx_pkg::lbx_field0_t record(input logic [31:0] v,
                                                  input logic so);
    record.lt = v[31];
    record.gt = !v[31] && (v != lbx_pkg::ZERO_WORD);
    record.eq = (v == lbx_pkg::ZERO_WORD);
    record.so = so;
  endfunction

  // Instruction fields, bit 0 of the instruction word is the MSB
  logic [5:0] opcode;
  logic [9:0] ext_op;
  logic [4:0] source_reg;
  logic [4:0] dest_or_first_reg;
  logic [4:0] second_reg;
  logic [4:0] branch_options;
  logic [1:0] condition_bit_select;
  logic [2:0] crf_bits;
  logic [15:0] unsigned_immediate;
  logic [23:0] long_displacement;
  logic [13:0] cond_displacement;
  logic absolute_addr_bit;
  logic link_bit;
  logic record_bit;
  assign opcode = issue_i.instr[31:26];
  assign source_reg = issue_i.instr[25:21];
  assign branch_options = issue_i.instr[25:21];
  assign dest_or_first_reg = issue_i.instr[20:16];
  assign crf_bits = issue_i.instr[20:18];
  assign condition_bit_select = issue_i.instr[17:16];
  assign second_reg = issue_i.instr[15:11];
  assign ext_op = issue_i.instr[10:1];
  assign unsigned_immediate = issue_i.instr[15:0];
  assign long_displacement = issue_i.instr[25:2];
  assign cond_displacement = issue_i.instr[15:2];
  assign absolute_addr_bit = issue_i.instr[1];
  assign link_bit = issue_i.instr[0];
  assign record_bit = issue_i.instr[0];

  logic is_andc, is_andi, is_andis, is_b, is_cbr, is_bcctr, is_bclr, is_cond;
  assign is_andc = opcode == lbx_pkg::OP_X_FORM && ext_op == lbx_pkg::XO_ANDC;
  assign is_andi = opcode == lbx_pkg::OP_ANDI;
  assign is_andis = opcode == lbx_pkg::OP_ANDIS;
  assign is_b = opcode == lbx_pkg::OP_BRANCH;
  assign is_cbr = opcode == lbx_pkg::OP_COND_BRANCH;
  assign is_bcctr = opcode == lbx_pkg::OP_XL_FORM &&
                    ext_op == lbx_pkg::XO_TO_COUNT;
  assign is_bclr = opcode == lbx_pkg::OP_XL_FORM &&
                   ext_op == lbx_pkg::XO_TO_LINK;
  assign is_cond = is_cbr || is_bcctr || is_bclr;

  // Logic results
  logic [31:0] logic_res;
  logic logic_regs_ok;
  always_comb begin
    logic_res = issue_i.src_val & ~issue_i.second_val;
    if (is_andi) begin
      logic_res = issue_i.src_val &
                  {lbx_pkg::ZERO_HALF, unsigned_immediate};
    end else if (is_andis) begin
      logic_res = issue_i.src_val &
                  {unsigned_immediate, lbx_pkg::ZERO_HALF};
    end
  end
  assign logic_regs_ok = reg_ok(source_reg) && reg_ok(dest_or_first_reg) &&
                         (!is_andc || reg_ok(second_reg));

  // Branch evaluation; option bit 4 and hint bits 19:20 stay out
  logic [31:0] seq_addr;
  logic [31:0] disp;
  logic [31:0] base;
  logic [31:0] dec_count;
  logic count_ok, cond_ok, taken, decrement, illegal_cond;
  logic [31:0] target;
  assign seq_addr = issue_i.cur_addr + lbx_pkg::INSTR_STEP;
  assign disp = is_b ?
    {{6{long_displacement[23]}}, long_displacement, lbx_pkg::ZERO_LOW2} :
    {{16{cond_displacement[13]}}, cond_displacement,
     lbx_pkg::ZERO_LOW2};
  assign base = absolute_addr_bit ? lbx_pkg::ZERO_WORD :
                issue_i.cur_addr;
  assign decrement = (is_cbr || is_bclr) &&
                     !branch_options[lbx_pkg::OPT2];
  assign dec_count = decrement ? count_register - lbx_pkg::ONE_WORD :
                     count_register;
  assign count_ok = branch_options[lbx_pkg::OPT2] ||
                    ((dec_count == lbx_pkg::ZERO_WORD) ==
                     branch_options[lbx_pkg::OPT3]);
  // Field zero bits in order lt, gt, eq, so; select 0 picks lt
  assign cond_ok = branch_options[lbx_pkg::OPT0] ||
                   (field0[~condition_bit_select] ==
                    branch_options[lbx_pkg::OPT1]);
  assign taken = is_b || (count_ok && cond_ok);
  assign illegal_cond = is_cond && ((crf_bits != lbx_pkg::ZERO_CRF) ||
    (is_bcctr && !branch_options[lbx_pkg::OPT2]));
  always_comb begin
    target = base + disp;
    if (is_bcctr) begin
      target = {count_register[31:2], lbx_pkg::ZERO_LOW2};
    end else if (is_bclr) begin
      target = {link_register[31:2], lbx_pkg::ZERO_LOW2};
    end
  end

  logic known, illegal_now, is_logic;
  assign is_logic = is_andc || is_andi || is_andis;
  assign known = is_logic || is_b || is_cond;
  assign illegal_now = issue_i.valid && known &&
                       ((is_logic && !logic_regs_ok) || illegal_cond);

  always_comb begin
    next_state = lbx_pkg::LBX_IDLE;
    case (state)
      lbx_pkg::LBX_IDLE, lbx_pkg::LBX_DONE, lbx_pkg::LBX_ILLEGAL: begin
        if (illegal_now) begin
          next_state = lbx_pkg::LBX_ILLEGAL;
        end else if (issue_i.valid && known) begin
          next_state = lbx_pkg::LBX_DONE;
        end
      end
      default: next_state = lbx_pkg::LBX_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= lbx_pkg::LBX_IDLE;
      done_o <= 1'b0;
      illegal_o <= 1'b0;
    end else begin
      state <= next_state;
      done_o <= next_state == lbx_pkg::LBX_DONE;
      illegal_o <= next_state == lbx_pkg::LBX_ILLEGAL;
    end
  end

  logic ok_now;
  assign ok_now = issue_i.valid && known && !illegal_now;

  // Destination write
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      gpr_wr_o <= '0;
    end else begin
      gpr_wr_o.wr_en <= ok_now && is_logic;
      gpr_wr_o.dest_or_first_reg <= dest_or_first_reg;
      gpr_wr_o.data <= logic_res;
    end
  end

  // Condition field zero
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      field0 <= lbx_pkg::FIELD0_RESET;
    end else if (ok_now && (is_andi || is_andis ||
                            (is_andc && record_bit))) begin
      field0 <= record(logic_res, issue_i.so);
    end
  end
  assign condition_field_zero_o = field0;

  // Count and link registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_register <= lbx_pkg::ZERO_WORD;
    end else if (ok_now && decrement) begin
      count_register <= dec_count;
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      link_register <= lbx_pkg::ZERO_WORD;
    end else if (ok_now && (is_b || is_cond) && link_bit) begin
      link_register <= seq_addr;
    end
  end
  assign count_register_o = count_register;
  assign link_register_o = link_register;

  // Next address
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      next_instr_address_o <= lbx_pkg::ZERO_WORD;
      redirect_o <= 1'b0;
    end else if (ok_now) begin
      next_instr_address_o <= (is_b || is_cond) && taken ? target :
                              seq_addr;
      redirect_o <= (is_b || is_cond) && taken;
    end else begin
      redirect_o <= 1'b0;
    end
  end

  field_record_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ok_now && is_andi |=> field0.eq == ($past(logic_res) == 32'h0))
    else $error("andi record mismatch");
  andc_data_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ok_now && is_andc |=> gpr_wr_o.wr_en &&
    gpr_wr_o.data == ($past(issue_i.src_val) & ~$past(issue_i.second_val)))
    else $error("andc result wrong");
  link_write_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ok_now && is_cond && link_bit |=>
    link_register == $past(issue_i.cur_addr) + 32'h4)
    else $error("link not written");
  count_dec_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ok_now && decrement |=>
    count_register == $past(count_register) - 32'h1)
    else $error("count not decremented");
  illegal_crf_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    issue_i.valid && is_cond && crf_bits != 3'h0 |=> illegal_o
    && !done_o)
    else $error("bad field not illegal");
  count_form_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    issue_i.valid && is_bcctr && !branch_options[2] |=>
    illegal_o && $stable(count_register))
    else $error("branch to count form not illegal");
  b_target_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ok_now && is_b && !absolute_addr_bit |=> redirect_o &&
    next_instr_address_o == $past(issue_i.cur_addr) + $past(disp))
    else $error("branch target wrong");
  not_taken_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ok_now && is_cond && !taken |=> !redirect_o &&
    next_instr_address_o == $past(seq_addr))
    else $error("fallthrough wrong");
  cv_cond_taken: cover property (@(posedge clk_i) ok_now && is_cbr && taken);
  cv_bclr: cover property (@(posedge clk_i) ok_now && is_bclr && decrement);
  cv_illegal: cover property (@(posedge clk_i) illegal_now);
endmodule

// ---- rtl/lbx_pkg.sv ----
// Package: encodings, field positions and types for the logic/branch stage
package lbx_pkg;
  localparam logic [5:0] OP_X_FORM = 6'h1F;
  localparam logic [9:0] XO_ANDC = 10'h03C;
  localparam logic [5:0] OP_ANDI = 6'h1C;
  localparam logic [5:0] OP_ANDIS = 6'h1D;
  localparam logic [5:0] OP_BRANCH = 6'h12;
  localparam logic [5:0] OP_COND_BRANCH = 6'h10;
  localparam logic [5:0] OP_XL_FORM = 6'h13;
  localparam logic [9:0] XO_TO_COUNT = 10'h210;
  localparam logic [9:0] XO_TO_LINK = 10'h010;
  localparam logic [31:0] INSTR_STEP = 32'h0000_0004;
  localparam logic [31:0] ONE_WORD = 32'h0000_0001;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [15:0] ZERO_HALF = 16'h0000;
  localparam logic [1:0] ZERO_LOW2 = 2'h0;
  localparam logic [2:0] ZERO_CRF = 3'h0;
  localparam logic [3:0] FIELD0_RESET = 4'h0;
  // Number of general registers the core implements
  localparam logic [5:0] NUM_GPRS = 6'h20;
  // Branch option bit positions, numbered from the MSB of the field
  localparam int OPT0 = 4;
  localparam int OPT1 = 3;
  localparam int OPT2 = 2;
  localparam int OPT3 = 1;

  typedef struct packed {
    logic valid;
    logic [31:0] instr;
    logic [31:0] cur_addr;
    logic [31:0] src_val;
    logic [31:0] second_val;
    logic so;
  } lbx_issue_t;

  typedef struct packed {
    logic wr_en;
    logic [4:0] dest_or_first_reg;
    logic [31:0] data;
  } lbx_gpr_wr_t;

  typedef struct packed {
    logic lt;
    logic gt;
    logic eq;
    logic so;
  } lbx_field0_t;

  typedef enum logic [1:0] {
    LBX_IDLE = 2'b00,
    LBX_DONE = 2'b01,
    LBX_ILLEGAL = 2'b10
  } lbx_state_t;
endpackage

// ---- tb/test_lbx_exec.sv ----
// Self-checking random bench for the logic and branch execute stage
`timescale 1ns/100ps
module test_lbx_exec;
  logic clk_i;
  logic rst_i;
  lbx_pkg::lbx_issue_t issue_i;
  lbx_pkg::lbx_gpr_wr_t gpr_wr_o;
  lbx_pkg::lbx_field0_t fz_o;
  logic [31:0] cnt_o, lnk_o, nxt_o;
  logic red_o, done_o, ill_o;
  int fails, total_checks, cycles;
  logic [31:0] seed, e_cnt, e_lnk, e_nxt, e_data;
  logic [3:0] e_fz;
  logic e_done, e_ill, e_red, e_wr;

  lbx_exec lbx_exec_i (.clk_i(clk_i), .rst_i(rst_i), .issue_i(issue_i),
    .gpr_wr_o(gpr_wr_o), .condition_field_zero_o(fz_o),
    .count_register_o(cnt_o), .link_register_o(lnk_o),
    .next_instr_address_o(nxt_o), .redirect_o(red_o), .done_o(done_o),
    .illegal_o(ill_o));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [3:0] crf(logic [31:0] r, logic so);
    return {r[31], !r[31] && (r != 32'h0000_0000), r == 32'h0000_0000, so};
  endfunction

  // Works out the outcome of one instruction and advances the bench state
  function automatic void model(lbx_pkg::lbx_issue_t s);
    logic [4:0] opt;
    logic [1:0] sel;
    logic [31:0] cn, tgt;
    logic ok_cnt, ok_cnd, bad3;
    opt = s.instr[25:21];
    sel = s.instr[17:16];
    bad3 = s.instr[20:18] != 3'h0;
    {e_done, e_ill, e_red, e_wr} = 4'h0;
    cn = e_cnt;
    tgt = 32'h0000_0000;
    e_data = 32'h0000_0000;
    case (s.instr[31:26])
      lbx_pkg::OP_X_FORM: if (s.instr[10:1] == lbx_pkg::XO_ANDC) begin
        e_data = s.src_val & ~s.second_val;
        if (s.instr[0]) e_fz = crf(e_data, s.so);
      end
      lbx_pkg::OP_ANDI: e_data = s.src_val & {16'h0000, s.instr[15:0]};
      lbx_pkg::OP_ANDIS: e_data = s.src_val & {s.instr[15:0], 16'h0000};
      lbx_pkg::OP_BRANCH: begin
        tgt = {{6{s.instr[25]}}, s.instr[25:2], 2'h0};
        e_done = 1'b1;
        e_red = 1'b1;
      end
      lbx_pkg::OP_COND_BRANCH: begin
        e_ill = bad3;
        tgt = {{16{s.instr[15]}}, s.instr[15:2], 2'h0};
      end
      lbx_pkg::OP_XL_FORM: begin
        if (s.instr[10:1] == lbx_pkg::XO_TO_COUNT) begin
          e_ill = bad3 || !opt[2];
          tgt = {e_cnt[31:2], 2'h0};
        end else if (s.instr[10:1] == lbx_pkg::XO_TO_LINK) begin
          e_ill = bad3;
          tgt = {e_lnk[31:2], 2'h0};
        end
      end
      default: ;
    endcase
    e_wr = s.instr[31:26] == lbx_pkg::OP_ANDI ||
      s.instr[31:26] == lbx_pkg::OP_ANDIS ||
      (s.instr[31:26] == lbx_pkg::OP_X_FORM &&
      s.instr[10:1] == lbx_pkg::XO_ANDC);
    if (s.instr[31:26] == lbx_pkg::OP_ANDI ||
        s.instr[31:26] == lbx_pkg::OP_ANDIS) e_fz = crf(e_data, s.so);
    if ((s.instr[31:26] == lbx_pkg::OP_BRANCH ||
        s.instr[31:26] == lbx_pkg::OP_COND_BRANCH) && !s.instr[1])
      tgt = tgt + s.cur_addr;
    if (!e_ill && (s.instr[31:26] == lbx_pkg::OP_COND_BRANCH ||
        (s.instr[31:26] == lbx_pkg::OP_XL_FORM &&
        (s.instr[10:1] == lbx_pkg::XO_TO_COUNT ||
        s.instr[10:1] == lbx_pkg::XO_TO_LINK)))) begin
      if (!opt[2]) cn = e_cnt - 32'h0000_0001;
      ok_cnt = opt[2] || ((cn == 32'h0000_0000) == opt[1]);
      ok_cnd = opt[4] || (e_fz[2'd3 - sel] == opt[3]);
      e_red = ok_cnt && ok_cnd;
      e_done = 1'b1;
    end
    if (e_wr) e_done = 1'b1;
    if (e_done) begin
      e_cnt = cn;
      e_nxt = e_red ? tgt : s.cur_addr + 32'h0000_0004;
      if (!e_wr && s.instr[0]) e_lnk = s.cur_addr + 32'h0000_0004;
    end
  endfunction

  task automatic chk1(string n, logic e, logic g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic chk32(string n, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic step(logic [31:0] ins, logic [31:0] src, logic [31:0] sec,
      logic so);
    logic [31:0] c;
    c = rnd();
    issue_i = {1'b1, ins, c[31:2], 2'h0, src, sec, so};
    model(issue_i);
    @(posedge clk_i);
    #1;
    chk1("done", e_done, done_o);
    chk1("illegal", e_ill, ill_o);
    chk1("redirect", e_red, red_o);
    chk1("write", e_wr, gpr_wr_o.wr_en);
    if (e_wr) chk32("data", e_data, gpr_wr_o.data);
    if (e_wr) chk32("dest", {27'h0, ins[20:16]},
      {27'h0, gpr_wr_o.dest_or_first_reg});
    if (e_done) chk32("next", e_nxt, nxt_o);
    chk32("field0", {28'h0, e_fz}, {28'h0, fz_o});
    chk32("count", e_cnt, cnt_o);
    chk32("link", e_lnk, lnk_o);
  endtask

  task automatic reset_run(int n);
    issue_i = '0;
    rst_i = 1'b1;
    repeat (n) @(posedge clk_i);
    #1;
    {e_cnt, e_lnk, e_fz} = '0;
    chk32("reset count", 32'h0000_0000, cnt_o);
    chk32("reset link", e_lnk, lnk_o);
    chk32("reset next", 32'h0000_0000, nxt_o);
    chk32("reset field0", 32'h0000_0000, {28'h0, fz_o});
    chk1("reset done", 1'b0, done_o);
    chk1("reset redirect", 1'b0, red_o);
    chk1("reset illegal", 1'b0, ill_o);
    chk1("reset write", 1'b0, gpr_wr_o.wr_en);
    rst_i = 1'b0;
  endtask

  task automatic test_done();
    $display("Checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      test_done();
    end
  end

  initial begin
    logic [31:0] a;
    logic [2:0] z;
    {fails, total_checks, cycles} = '0;
    seed = 32'h0001_554F;
    rst_i = 1'b1;
    issue_i = '0;
    @(posedge clk_i);
    #1;
    reset_run(16);
    step({lbx_pkg::OP_X_FORM, 15'h1485, lbx_pkg::XO_ANDC, 1'b1},
      32'hFFFF_0000, 32'h0000_FFFF, 1'b1);
    step({lbx_pkg::OP_ANDI, 10'h0C4, 16'h00FF}, 32'hFFFF_0000,
      32'h0, 1'b0);
    step({lbx_pkg::OP_ANDIS, 10'h0C4, 16'h8000}, 32'h8000_0001,
      32'h0, 1'b0);
    step({lbx_pkg::OP_BRANCH, 24'h80_0000, 2'h3}, 32'h0, 32'h0, 1'b0);
    step({lbx_pkg::OP_COND_BRANCH, 5'h10, 5'h00, 16'h8001}, 32'h0, 32'h0,
      1'b0);
    step({lbx_pkg::OP_COND_BRANCH, 5'h14, 5'h08, 16'h0004}, 32'h0, 32'h0,
      1'b0);
    step({lbx_pkg::OP_XL_FORM, 5'h10, 10'h003, lbx_pkg::XO_TO_COUNT, 1'b1},
      32'h0, 32'h0, 1'b0);
    step({lbx_pkg::OP_XL_FORM, 5'h14, 10'h003, lbx_pkg::XO_TO_LINK, 1'b1},
      32'h0, 32'h0, 1'b0);
    for (int i = 0; i < 600; i++) begin
      a = rnd();
      z = (a[8:5] == 4'h0) ? a[11:9] : 3'h0;
      if (i == 300) reset_run(2);
      case (a[30:28])
        3'h0: step({lbx_pkg::OP_X_FORM, a[14:0], lbx_pkg::XO_ANDC, a[15]},
          rnd(), rnd(), a[31]);
        3'h1: step({lbx_pkg::OP_ANDI, a[25:0]}, rnd(), rnd(), a[31]);
        3'h2: step({lbx_pkg::OP_ANDIS, a[25:0]}, rnd(), rnd(), a[31]);
        3'h3: step({lbx_pkg::OP_BRANCH, a[25:0]}, 32'h0, 32'h0, 1'b0);
        3'h4: step({lbx_pkg::OP_COND_BRANCH, a[4:0], z, a[17:0]}, 32'h0,
          32'h0, 1'b0);
        3'h5: step({lbx_pkg::OP_XL_FORM, a[4:0], z, a[17:16], 3'h0, a[12:11],
          lbx_pkg::XO_TO_COUNT, a[0]}, 32'h0, 32'h0, 1'b0);
        3'h6: step({lbx_pkg::OP_XL_FORM, a[4:0], 3'h0, a[17:16], 3'h0,
          a[12:11], lbx_pkg::XO_TO_LINK, a[0]}, 32'h0, 32'h0, 1'b0);
        default: step({6'h00, a[25:0]}, 32'h0, 32'h0, 1'b0);
      endcase
    end
    issue_i.valid = 1'b0;
    test_done();
  end
endmodule
